// File: core/ebc_pkg.sv
/*
 * Shared constants and types for the external bus cycle controller:
 * request and answer carriers, access sizes, bus states, strobe codes
 * and the address windows used by the fetch checks.
 * Assumes a single core clock and a 16-bit multiplexed external bus.
 */
package ebc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths and requester slots (slot number is also the rank, 0 highest)
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int BUS_W = 16;
    localparam int NUM_REQ = 4;
    localparam logic [1:0] REQ_DMA = 2'h0;
    localparam logic [1:0] REQ_OPND = 2'h1;
    localparam logic [1:0] REQ_BRANCH = 2'h2;
    localparam logic [1:0] REQ_SEQ = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Address windows seen by the fetch checks (plain defaults)
    localparam logic [ADDR_W-1:0] PERIPH_BASE = 24'hfff000;
    localparam logic [ADDR_W-1:0] PERIPH_LAST = 24'hffffff;

    ////////////////////////////////////////////////////////////////////////
    // Write strobe pairs, written {upper, lower}
    localparam logic [1:0] STRB_ODD = 2'h1;
    localparam logic [1:0] STRB_EVEN = 2'h2;
    localparam logic [1:0] STRB_BOTH = 2'h0;
    localparam logic [1:0] STRB_IDLE = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset for pins and buses
    localparam logic PIN_HIGH_RST = 1'b1;
    localparam logic [BUS_W-1:0] BUS_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        EBC_SZ_BYTE = 2'h0,
        EBC_SZ_HALF = 2'h1,
        EBC_SZ_WORD = 2'h2
    } ebc_size_e;

    // Gray codes along idle, T1, T2, T3, idle-in, hold, idle-out
    typedef enum logic [2:0] {
        EBC_ST_IDLE = 3'h0,
        EBC_ST_T1 = 3'h1,
        EBC_ST_T2 = 3'h3,
        EBC_ST_T3 = 3'h2,
        EBC_ST_TI_IN = 3'h6,
        EBC_ST_TH = 3'h7,
        EBC_ST_TI_OUT = 3'h5
    } ebc_state_e;

    typedef struct packed {
        logic valid;
        logic write;
        logic rmw;
        ebc_size_e size;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ebc_req_s;

    typedef struct packed {
        logic done;
        logic err;
        logic [DATA_W-1:0] rdata;
    } ebc_rsp_s;

endpackage : ebc_pkg

// File: core/ebc_piece_plan.sv
/*
 * Piece planner: splits one access into the bus cycles a 16-bit bus needs
 * and steers write data and strobes onto the proper byte lanes.
 * Purely combinational; the caller registers what it uses.
 */
`timescale 1ns/1ps
`default_nettype none

module ebc_piece_plan (
    input wire ebc_pkg::ebc_size_e size,
    input wire logic [1:0] addr_lo,
    input wire logic [1:0] piece,
    input wire logic [ebc_pkg::DATA_W-1:0] wdata,
    output logic [1:0] offset,
    output logic is_byte,
    output logic is_odd,
    output logic last,
    output logic [ebc_pkg::BUS_W-1:0] lane_data,
    output logic [1:0] strobe_n
);
    import ebc_pkg::*;

    logic [DATA_W-1:0] shifted;
    logic [1:0] lo_sum;

    ////////////////////////////////////////////////////////////////////////
    // Piece table: byte offset, width and last flag per piece
    always_comb begin
        offset = 2'h0;
        is_byte = 1'b0;
        last = 1'b1;
        unique case (size)
            EBC_SZ_HALF: begin
                if (addr_lo[0]) begin
                    // Odd halfword goes out as two bytes
                    is_byte = 1'b1;
                    offset = {1'b0, piece[0]};
                    last = piece[0];
                end
            end
            EBC_SZ_WORD: begin
                if (addr_lo[0]) begin
                    // Byte, halfword, byte
                    unique case (piece)
                        2'h0: begin
                            is_byte = 1'b1;
                            last = 1'b0;
                        end
                        2'h1: begin
                            offset = 2'h1;
                            last = 1'b0;
                        end
                        default: begin
                            is_byte = 1'b1;
                            offset = 2'h3;
                        end
                    endcase
                end else begin
                    // Two halfwords, both at 00 and at 10
                    offset = {piece[0], 1'b0};
                    last = piece[0];
                end
            end
            default: is_byte = 1'b1; // Byte, and the unused code treated alike
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Lane steering: odd byte rides the upper lane, even byte the lower
    assign lo_sum = addr_lo + offset;
    assign is_odd = lo_sum[0];
    assign shifted = wdata >> {offset, 3'h0};
    assign lane_data = is_byte ? {2{shifted[7:0]}} : shifted[BUS_W-1:0];
    assign strobe_n = !is_byte ? STRB_BOTH : (is_odd ? STRB_ODD : STRB_EVEN);

endmodule : ebc_piece_plan

`default_nettype wire

// File: core/ebc_cycle_ctrl.sv
/*
 * External bus cycle controller: ranks bus hold and four internal
 * requesters, runs T1/T2/T3 multiplexed bus cycles, splits misaligned
 * accesses, steers byte lanes and runs the hold handshake.
 * Assumes requesters on core_clk that hold valid until they see done and
 * drop it on the next edge, and an external party that drives read data
 * by the end of T2 and keeps it through T3.
 */
// Functional notes
// - Rank: hold, DMA, operand, branch, sequential fetch
// - Fetch may slip between RMW read and write
// - No fetch or hold inside split access
// - No sequential prefetch into peripheral I/O
// - Sequential fetch never crosses into external memory
// - Any alignment accepted; misaligned needs several cycles
// - Odd halfword: two byte cycles
// - Odd word: byte, halfword, byte cycles
// - Word at 10: two halfword cycles
// - Read byte taken from its own lane
// - Strobes low only during data transfer
// - Hold seen in T2 and T3 enters after T3
// - Each hold state resamples request, stay or resume
// - Idle state always surrounds hold
// - Bus released while held, driven again after
// - Hold acknowledge low exactly during hold
`timescale 1ns/1ps
`default_nettype none

module ebc_cycle_ctrl (
    input wire logic core_clk,
    input wire logic srst,
    input wire ebc_pkg::ebc_req_s [ebc_pkg::NUM_REQ-1:0] req,
    output ebc_pkg::ebc_rsp_s [ebc_pkg::NUM_REQ-1:0] rsp,
    input wire logic fetch_from_internal,
    input wire logic hold_request_n,
    output logic hold_ack_n,
    output logic address_latch,
    output logic read_strobe_n,
    output logic upper_byte_write_strobe_n,
    output logic lower_byte_write_strobe_n,
    output logic [ebc_pkg::ADDR_W-ebc_pkg::BUS_W-1:0] addr_high,
    output logic [ebc_pkg::BUS_W-1:0] muxed_addr_data_bus_out,
    output logic muxed_addr_data_bus_oe,
    input wire logic [ebc_pkg::BUS_W-1:0] muxed_addr_data_bus_in
);
    import ebc_pkg::*;

    ebc_state_e state, next_state;
    ebc_req_s cur_req, next_req;
    logic [1:0] cur_idx, next_idx, piece, next_piece;
    logic cur_last, cur_byte, cur_odd, cur_first;
    logic [1:0] cur_off;
    logic hold_meta, hold_sync, hold_seen, idle_hold_seen, rmw_pending, rmw_hold;
    logic [BUS_W-1:0] ad_meta, ad_sync;
    logic cap_pend, cap_byte, cap_odd, cap_first, cap_last;
    logic [1:0] cap_off, cap_idx;
    logic [DATA_W-1:0] rbuf, next_rbuf;
    logic [NUM_REQ-1:0] elig;
    logic [1:0] pick;
    logic pick_valid, pick_legal, hold_s, hold_go, boundary, grant, refuse;
    logic [1:0] p_off, p_strobe;
    logic p_byte, p_odd, p_last;
    logic [BUS_W-1:0] p_lane;
    logic [ADDR_W-1:0] p_addr;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hold_meta <= PIN_HIGH_RST;
            hold_sync <= PIN_HIGH_RST;
            ad_meta <= BUS_RST;
            ad_sync <= BUS_RST;
        end else begin
            hold_meta <= hold_request_n;
            hold_sync <= hold_meta;
            ad_meta <= muxed_addr_data_bus_in;
            ad_sync <= ad_meta;
        end
    end

    assign hold_s = !hold_sync;

    ////////////////////////////////////////////////////////////////////////
    // Fixed-rank pick; the slot finishing now is masked so it is not rerun
    function automatic logic [1:0] first_set(input logic [NUM_REQ-1:0] v);
        first_set = REQ_SEQ;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 2'(i);
            end
        end
    endfunction : first_set

    function automatic logic in_periph(input logic [ADDR_W-1:0] a);
        in_periph = (a >= PERIPH_BASE) && (a <= PERIPH_LAST);
    endfunction : in_periph

    for (genvar g = 0; g < NUM_REQ; g++) begin : g_elig
        assign elig[g] = req[g].valid && !rsp[g].done
                         && !(cap_pend && cap_idx == 2'(g))
                         && !(state == EBC_ST_T3 && cur_idx == 2'(g));
    end

    assign pick = first_set(elig);
    assign pick_valid = |elig;
    // Sequential fetch: never into peripheral space, never out of internal code
    assign pick_legal = !(pick == REQ_SEQ
                          && (in_periph(req[pick].addr) || fetch_from_internal));
    assign boundary = (state == EBC_ST_IDLE) || (state == EBC_ST_T3 && cur_last);
    // Hold is refused inside a split access and from T3 of an RMW read to its write
    assign rmw_hold = (state == EBC_ST_T3 && cur_idx == REQ_OPND)
                      ? (cur_req.rmw && !cur_req.write) : rmw_pending;
    assign hold_go = !rmw_hold && hold_s
                     && ((state == EBC_ST_T3 && cur_last && hold_seen)
                         || (state == EBC_ST_IDLE && idle_hold_seen));
    assign grant = boundary && !hold_go && pick_valid && pick_legal;
    assign refuse = boundary && !hold_go && pick_valid && !pick_legal;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            EBC_ST_IDLE: begin
                if (hold_go) begin
                    next_state = EBC_ST_TI_IN;
                end else if (grant) begin
                    next_state = EBC_ST_T1;
                end
            end
            EBC_ST_T1: next_state = EBC_ST_T2;
            EBC_ST_T2: next_state = EBC_ST_T3;
            EBC_ST_T3: begin
                if (!cur_last) begin
                    next_state = EBC_ST_T1;
                end else if (hold_go) begin
                    next_state = EBC_ST_TI_IN;
                end else if (grant) begin
                    next_state = EBC_ST_T1;
                end else begin
                    next_state = EBC_ST_IDLE;
                end
            end
            EBC_ST_TI_IN: next_state = EBC_ST_TH;
            EBC_ST_TH: next_state = hold_s ? EBC_ST_TH : EBC_ST_TI_OUT;
            EBC_ST_TI_OUT: next_state = EBC_ST_IDLE;
            default: next_state = EBC_ST_IDLE;
        endcase
    end

    always_comb begin
        next_req = cur_req;
        next_idx = cur_idx;
        next_piece = piece;
        if (state == EBC_ST_T3 && !cur_last) begin
            next_piece = piece + 2'h1;
        end else if (grant) begin
            next_req = req[pick];
            next_idx = pick;
            next_piece = 2'h0;
        end
    end

    ebc_piece_plan u_plan (
        .size(next_req.size),
        .addr_lo(next_req.addr[1:0]),
        .piece(next_piece),
        .wdata(next_req.wdata),
        .offset(p_off),
        .is_byte(p_byte),
        .is_odd(p_odd),
        .last(p_last),
        .lane_data(p_lane),
        .strobe_n(p_strobe)
    );

    assign p_addr = next_req.addr + ADDR_W'(p_off);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and current piece
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= EBC_ST_IDLE;
            cur_req <= '0;
            cur_idx <= REQ_DMA;
            piece <= 2'h0;
            cur_last <= 1'b1;
            cur_byte <= 1'b0;
            cur_odd <= 1'b0;
            cur_off <= 2'h0;
            cur_first <= 1'b1;
        end else begin
            state <= next_state;
            cur_req <= next_req;
            cur_idx <= next_idx;
            piece <= next_piece;
            cur_last <= p_last;
            cur_byte <= p_byte;
            cur_odd <= p_odd;
            cur_off <= p_off;
            cur_first <= (next_piece == 2'h0);
        end
    end

    // Hold sampling: seen in T2, confirmed in T3; idle bus needs two samples
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hold_seen <= 1'b0;
            idle_hold_seen <= 1'b0;
        end else begin
            hold_seen <= (state == EBC_ST_T2) ? hold_s : (hold_seen && state == EBC_ST_T3);
            idle_hold_seen <= (state == EBC_ST_IDLE) && hold_s;
        end
    end

    // RMW window: hold stays out, fetches may still be granted
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rmw_pending <= 1'b0;
        end else if (state == EBC_ST_T3 && cur_last && cur_idx == REQ_OPND) begin
            rmw_pending <= cur_req.rmw && !cur_req.write;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read capture: synced bus holds the T2 value one cycle after T3
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cap_pend <= 1'b0;
            cap_byte <= 1'b0;
            cap_odd <= 1'b0;
            cap_first <= 1'b0;
            cap_last <= 1'b0;
            cap_off <= 2'h0;
            cap_idx <= REQ_DMA;
            rbuf <= DATA_RST;
        end else begin
            cap_pend <= (state == EBC_ST_T3) && !cur_req.write;
            cap_byte <= cur_byte;
            cap_odd <= cur_odd;
            cap_first <= cur_first;
            cap_last <= cur_last;
            cap_off <= cur_off;
            cap_idx <= cur_idx;
            if (cap_pend) begin
                rbuf <= next_rbuf;
            end
        end
    end

    // The first piece starts from zero so no old bytes leak in
    always_comb begin
        next_rbuf = cap_first ? DATA_RST : rbuf;
        if (cap_byte) begin
            next_rbuf[{cap_off, 3'h0} +: 8] = cap_odd ? ad_sync[15:8] : ad_sync[7:0];
        end else begin
            next_rbuf[{cap_off, 3'h0} +: 16] = ad_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Answers: writes end with T3, reads with the capture cycle
    for (genvar g = 0; g < NUM_REQ; g++) begin : g_rsp
        always_ff @(posedge core_clk) begin
            if (srst) begin
                rsp[g] <= '0;
            end else begin
                rsp[g].done <= (state == EBC_ST_T3 && cur_last && cur_req.write
                                && cur_idx == 2'(g))
                               || (cap_pend && cap_last && cap_idx == 2'(g))
                               || (refuse && pick == 2'(g));
                rsp[g].err <= refuse && pick == 2'(g);
                if (cap_pend && cap_last && cap_idx == 2'(g)) begin
                    rsp[g].rdata <= next_rbuf;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins, registered from the next state so each comes from a flop
    always_ff @(posedge core_clk) begin
        if (srst) begin
            hold_ack_n <= PIN_HIGH_RST;
            address_latch <= 1'b0;
            read_strobe_n <= PIN_HIGH_RST;
            upper_byte_write_strobe_n <= PIN_HIGH_RST;
            lower_byte_write_strobe_n <= PIN_HIGH_RST;
            addr_high <= '0;
            muxed_addr_data_bus_out <= BUS_RST;
            muxed_addr_data_bus_oe <= 1'b0;
        end else begin
            hold_ack_n <= (next_state != EBC_ST_TH);
            address_latch <= (next_state == EBC_ST_T1);
            read_strobe_n <= !(!next_req.write
                               && (next_state == EBC_ST_T2 || next_state == EBC_ST_T3));
            if (next_req.write && (next_state == EBC_ST_T2 || next_state == EBC_ST_T3)) begin
                {upper_byte_write_strobe_n, lower_byte_write_strobe_n} <= p_strobe;
            end else begin
                {upper_byte_write_strobe_n, lower_byte_write_strobe_n} <= STRB_IDLE;
            end
            addr_high <= p_addr[ADDR_W-1:BUS_W];
            muxed_addr_data_bus_out <= (next_state == EBC_ST_T1) ? p_addr[BUS_W-1:0] : p_lane;
            // Released in idle and hold, driven again once hold ends
            muxed_addr_data_bus_oe <= (next_state == EBC_ST_T1)
                                      || (next_req.write && (next_state == EBC_ST_T2
                                                             || next_state == EBC_ST_T3));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_bus_cycle;
        state == EBC_ST_T1 ##1 state == EBC_ST_T2 ##1 state == EBC_ST_T3;
    endsequence

    sequence s_hold_exit;
        state == EBC_ST_TH ##1 state == EBC_ST_TI_OUT ##1 state == EBC_ST_IDLE;
    endsequence

    a_cycle_whole: assert property (@(posedge core_clk) disable iff (srst)
        $rose(state == EBC_ST_T1) |-> s_bus_cycle) else $error("bus cycle cut short");

    a_split_locked: assert property (@(posedge core_clk) disable iff (srst)
        (state == EBC_ST_T3 && !cur_last) |=> state == EBC_ST_T1 && cur_idx == $past(cur_idx))
        else $error("split access interrupted");

    a_hold_entry: assert property (@(posedge core_clk) disable iff (srst)
        $rose(state == EBC_ST_TH) |-> $past(state) == EBC_ST_TI_IN && $past(state, 2) != EBC_ST_TH)
        else $error("hold entered without idle state");

    a_hold_leave: assert property (@(posedge core_clk) disable iff (srst)
        (state == EBC_ST_TH && !hold_s) |-> s_hold_exit) else $error("hold exit wrong");

    a_ack_bus_free: assert property (@(posedge core_clk) disable iff (srst)
        (state == EBC_ST_TH) |-> !hold_ack_n && !muxed_addr_data_bus_oe && address_latch == 1'b0)
        else $error("bus driven or no ack in hold");

    a_strobe_quiet: assert property (@(posedge core_clk) disable iff (srst)
        (state != EBC_ST_T2 && state != EBC_ST_T3) || !cur_req.write
        |-> upper_byte_write_strobe_n && lower_byte_write_strobe_n)
        else $error("write strobe low outside data transfer");

    a_hold_needs_t2: assert property (@(posedge core_clk) disable iff (srst)
        (state == EBC_ST_T3 ##1 state == EBC_ST_TI_IN) |-> $past(hold_s, 2) && $past(hold_s))
        else $error("hold entered without two samples");

    a_dma_first: assert property (@(posedge core_clk) disable iff (srst)
        (grant && elig[REQ_DMA]) |=> cur_idx == REQ_DMA) else $error("dma not ranked first");

    a_odd_half_bytes: assert property (@(posedge core_clk) disable iff (srst)
        (state == EBC_ST_T1 && cur_req.size == EBC_SZ_HALF && cur_req.addr[0])
        |-> cur_byte && cur_last == piece[0]) else $error("odd halfword not two bytes");

    a_odd_word_mid: assert property (@(posedge core_clk) disable iff (srst)
        (state == EBC_ST_T1 && cur_req.size == EBC_SZ_WORD && cur_req.addr[0])
        |-> cur_byte == (piece != 2'h1) && cur_last == (piece == 2'h2))
        else $error("odd word pieces wrong");

    a_seq_no_cross: assert property (@(posedge core_clk) disable iff (srst)
        (grant && pick == REQ_SEQ) |-> !fetch_from_internal)
        else $error("sequential fetch left internal code");

endmodule : ebc_cycle_ctrl

`default_nettype wire

// File: dv/ebc_ext_mem.sv
/* External memory model on the multiplexed bus: reads answer from the piece
   address, writes are kept per byte. Assumes the controller's registered pins. */
`timescale 1ns/1ps
`default_nettype none

module ebc_ext_mem (
    input wire logic core_clk,
    input wire logic address_latch,
    input wire logic read_strobe_n,
    input wire logic upper_byte_write_strobe_n,
    input wire logic lower_byte_write_strobe_n,
    input wire logic [7:0] addr_high,
    input wire logic [15:0] bus_out,
    output logic [15:0] bus_in
);
    logic [23:0] a = 24'h000000;
    logic [15:0] last = 16'h0000;
    logic [7:0] wmem [logic [23:0]];

    // Piece address taken at the end of T1, bytes stored from their own lane
    always @(posedge core_clk) begin
        if (address_latch) a <= {addr_high, bus_out};
        if (!upper_byte_write_strobe_n) wmem[a | 24'h000001] = bus_out[15:8];
        if (!lower_byte_write_strobe_n) wmem[a & 24'hfffffe] = bus_out[7:0];
        last <= bus_in;
    end

    // Odd byte on the upper lane; outside reads the lanes toggle so no stale data passes
    assign bus_in = !read_strobe_n ? {(a[7:0] | 8'h01) ^ 8'h5a, (a[7:0] & 8'hfe) ^ 8'h5a}
        : ~last;
endmodule : ebc_ext_mem
`default_nettype wire

// File: dv/external_bus_cycle_control_tb.sv
/* Bench for the bus cycle controller: split accesses, lanes, ranking,
   refused fetches and hold. Assumes the memory model on the far side. */
`timescale 1ns/1ps
`default_nettype none

module external_bus_cycle_control_tb;
    import ebc_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    ebc_req_s [NUM_REQ-1:0] req = '0;
    ebc_rsp_s [NUM_REQ-1:0] rsp;
    logic fetch_from_internal = 1'b0;
    logic hold_request_n = 1'b1;
    logic hold_ack_n, address_latch, read_strobe_n, muxed_addr_data_bus_oe;
    logic upper_byte_write_strobe_n, lower_byte_write_strobe_n;
    logic [7:0] addr_high;
    logic [15:0] muxed_addr_data_bus_out, muxed_addr_data_bus_in;
    int mismatches = 0;
    int total_checks = 0;
    int pieces;
    logic err_seen, ack_seen, late;

    ebc_cycle_ctrl ebc_cycle_ctrl_inst (.core_clk, .srst, .req, .rsp, .fetch_from_internal,
        .hold_request_n, .hold_ack_n, .address_latch, .read_strobe_n, .addr_high,
        .upper_byte_write_strobe_n, .lower_byte_write_strobe_n, .muxed_addr_data_bus_out,
        .muxed_addr_data_bus_oe, .muxed_addr_data_bus_in);
    ebc_ext_mem ebc_ext_mem_inst (.core_clk, .address_latch, .read_strobe_n, .addr_high,
        .upper_byte_write_strobe_n, .lower_byte_write_strobe_n,
        .bus_out(muxed_addr_data_bus_out), .bus_in(muxed_addr_data_bus_in));

    initial forever #20 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////
    // Shared helpers; expected read bytes follow the model's address pattern
    function automatic logic [31:0] rexp(ebc_size_e sz, logic [23:0] a);
        logic [31:0] w;
        for (int i = 0; i < 4; i++) w[8*i+:8] = (a[7:0] + 8'(i)) ^ 8'h5a;
        if (sz == EBC_SZ_WORD) return w;
        return sz == EBC_SZ_HALF ? {16'h0000, w[15:0]} : {24'h000000, w[7:0]};
    endfunction : rexp

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // Counts T1 pulses and notes a hold seen before a later piece
    task automatic wait_done(int s);
        for (int i = 0; i < 60; i++) begin
            @(negedge core_clk);
            if (hold_ack_n === 1'b0) ack_seen = 1'b1;
            if (address_latch === 1'b1) begin
                pieces++;
                late = late | ack_seen;
            end
            if (rsp[s].done === 1'b1) begin
                err_seen = rsp[s].err;
                @(posedge core_clk);
                req[s].valid <= 1'b0;
                return;
            end
        end
        check("done", 1'b0, 1'b1);
        summarize();
    endtask : wait_done

    task automatic access(int s, logic wr, ebc_size_e sz, logic [23:0] a, logic [31:0] wd,
        int np, logic ex_err);
        @(posedge core_clk);
        req[s] <= '{1'b1, wr, 1'b0, sz, a, wd};
        pieces = 0;
        wait_done(s);
        check("pieces", pieces, np);
        check("err", err_seen, ex_err);
        if (!wr && !ex_err) check("rdata", rsp[s].rdata, rexp(sz, a));
    endtask : access

    task automatic wait_ack(logic v);
        for (int i = 0; i < 20 && hold_ack_n !== v; i++) @(negedge core_clk);
        check("ack", hold_ack_n, v);
        if (hold_ack_n !== v) summarize();
    endtask : wait_ack

    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_split();
        access(1, 0, EBC_SZ_HALF, 24'h000101, 0, 2, 0);
        access(1, 0, EBC_SZ_WORD, 24'h000203, 0, 3, 0);
        access(1, 0, EBC_SZ_WORD, 24'h000302, 0, 2, 0);
        access(1, 0, EBC_SZ_BYTE, 24'h000401, 0, 1, 0);
        access(1, 0, EBC_SZ_BYTE, 24'h000400, 0, 1, 0);
        access(1, 0, EBC_SZ_WORD, 24'h000500, 0, 2, 0);
        access(0, 1, EBC_SZ_WORD, 24'h000611, 32'h44332211, 3, 0);
        for (int i = 0; i < 4; i++) begin
            check("wbyte", ebc_ext_mem_inst.wmem[24'(24'h611 + i)], 8'(17 * (i + 1)));
        end
        access(0, 1, EBC_SZ_BYTE, 24'h000701, 32'h000000a5, 1, 0);
        check("odd lane", ebc_ext_mem_inst.wmem[24'h000701], 8'ha5);
        check("even lane", ebc_ext_mem_inst.wmem.exists(24'h000700), 0);
        $display("test split done");
    endtask : test_split

    task automatic test_rank();
        int ord[$];
        logic [2:0] d;
        @(posedge core_clk);
        for (int s = 0; s < 3; s++) req[s] <= '{1'b1, 1'b0, 1'b0, EBC_SZ_HALF, 24'(16 * s), 0};
        for (int i = 0; i < 100 && ord.size() < 3; i++) begin
            @(negedge core_clk);
            for (int s = 0; s < 3; s++) d[s] = rsp[s].done;
            for (int s = 0; s < 3; s++) if (d[s] === 1'b1) ord.push_back(s);
            @(posedge core_clk);
            for (int s = 0; s < 3; s++) if (d[s] === 1'b1) req[s].valid <= 1'b0;
        end
        for (int s = 0; s < 3; s++) check("rank", ord.size() > s ? ord[s] : 9, s);
        if (ord.size() < 3) summarize();
        $display("test rank done");
    endtask : test_rank

    task automatic test_fetch();
        access(3, 0, EBC_SZ_WORD, PERIPH_BASE, 0, 0, 1);
        fetch_from_internal <= 1'b1;
        access(3, 0, EBC_SZ_WORD, 24'h000800, 0, 0, 1);
        fetch_from_internal <= 1'b0;
        access(3, 0, EBC_SZ_WORD, 24'h000800, 0, 2, 0);
        $display("test fetch done");
    endtask : test_fetch

    task automatic test_hold();
        @(posedge core_clk);
        hold_request_n <= 1'b0;
        wait_ack(1'b0);
        repeat (4) @(negedge core_clk);
        check("bus oe", muxed_addr_data_bus_oe, 1'b0);
        check("held", hold_ack_n, 1'b0);
        @(posedge core_clk);
        hold_request_n <= 1'b1;
        wait_ack(1'b1);
        // Hold raised with a split read must wait for its last piece
        @(posedge core_clk);
        req[1] <= '{1'b1, 1'b0, 1'b0, EBC_SZ_WORD, 24'h000903, 0};
        hold_request_n <= 1'b0;
        {pieces, ack_seen, late} = '0;
        wait_done(1);
        check("split pieces", pieces, 3);
        check("hold inside", late, 1'b0);
        wait_ack(1'b0);
        @(posedge core_clk);
        hold_request_n <= 1'b1;
        wait_ack(1'b1);
        // No hold between the read and the write of a read-modify-write
        @(posedge core_clk);
        req[1] <= '{1'b1, 1'b0, 1'b1, EBC_SZ_HALF, 24'h000a00, 0};
        hold_request_n <= 1'b0;
        {pieces, ack_seen, late} = '0;
        wait_done(1);
        check("rmw hold", ack_seen, 1'b0);
        access(1, 1, EBC_SZ_HALF, 24'h000a00, 32'h0000beef, 1, 0);
        wait_ack(1'b0);
        @(posedge core_clk);
        hold_request_n <= 1'b1;
        wait_ack(1'b1);
        $display("test hold done");
    endtask : test_hold

    initial begin
        {ack_seen, late} = '0;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        test_split();
        test_rank();
        test_fetch();
        test_hold();
        summarize();
    end
endmodule : external_bus_cycle_control_tb
`default_nettype wire
